/* src/fan_params.svh */
/*
 register offsets, reset values, bit positions and counts of the fan
 and thermal configuration bank; assumes inclusion by its bare name
*/
`ifndef FAN_PARAMS_SVH
`define FAN_PARAMS_SVH

`define ADDR_MAIN_CFG 8'h00
`define ADDR_REMOTE_FRAC 8'h06
`define ADDR_FAN_SPEED 8'h08
`define ADDR_LOCAL_TEMP 8'h0a
`define ADDR_REMOTE_TEMP 8'h0b
`define ADDR_LOCAL_CORR 8'h0d
`define ADDR_REMOTE_CORR 8'h0e
`define ADDR_FAN_LIMIT 8'h10
`define ADDR_LOCAL_UPPER 8'h14
`define ADDR_LOCAL_LOWER 8'h15
`define ADDR_LOCAL_CRIT 8'h16
`define ADDR_REMOTE_UPPER 8'h18
`define ADDR_REMOTE_LOWER 8'h19
`define ADDR_REMOTE_CRIT 8'h1a

`define CFG_RESET 8'h90
`define FAN_LIMIT_RESET 8'hff
`define BYTE_ZERO 8'h00
`define FRAC_BITS 3

`define CFG_MONITOR 0
`define CFG_INT_EN 1
`define CFG_SPEED_SEL 2
`define CFG_INVERT 3
`define CFG_FAULT_EN 4
`define CFG_SRC_LO 5
`define CFG_SRC_HI 6
`define CFG_CTRL_SEL 7

`define SRC_REMOTE 2'h0
`define SRC_FASTEST 2'h3

`define FAN_FAIL_COUNT 5

// limit table: corr local, corr remote, 60,0,70 local, 80,0,100 remote
`define LIMIT_RESETS 64'h64_00_50_46_00_3c_00_00
`define LIMIT_DEPTH 8

`endif

/* src/fan_types_pkg.sv */
/*
 shared types of the fan and thermal configuration bank;
 assumes fan_params.svh carries the numeric constants
*/
package fan_types_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [1:0] src_field_t;
endpackage : fan_types_pkg

/* src/limit_mem.sv */
/*
 small register file for offsets and temperature limits, read data
 held in a register; assumes one synchronous active-low reset
*/
`timescale 1ns/10ps
module limit_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3,
    parameter logic [WIDTH*DEPTH-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data_ff
);
    logic [WIDTH-1:0] mem_ff [DEPTH];

    // each entry restores its own power-up value
    genvar i;
    for (i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                mem_ff[i] <= INIT[i*WIDTH +: WIDTH];
            end else if (wr_en && wr_idx == AW'(i)) begin
                mem_ff[i] <= wr_data;
            end
        end
    end

    // read data held until the next read
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data_ff <= '0;
        end else if (rd_en) begin
            rd_data_ff <= mem_ff[rd_idx];
        end
    end
endmodule : limit_mem

/* src/fail_filter.sv */
/*
 counts consecutive failed speed samples and raises a fault after the
 set number; assumes sample is a one-cycle pulse per monitoring cycle
*/
`timescale 1ns/10ps
module fail_filter #(
    parameter int FAIL_COUNT = 5
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sample,
    input wire logic fail,
    output logic fault_ff
);
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;

    // saturates so a long stall cannot wrap back to zero
    assign nxt_cnt = !fail ? 4'h0 :
                     (cnt_ff == 4'(FAIL_COUNT)) ? cnt_ff : cnt_ff + 4'h1;

    // any good sample releases the fault at once
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_ff <= 4'h0;
            fault_ff <= 1'b0;
        end else if (sample) begin
            cnt_ff <= nxt_cnt;
            fault_ff <= (nxt_cnt == 4'(FAIL_COUNT));
        end
    end

    a_fault_on_fifth: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        sample && fail && cnt_ff == 4'(FAIL_COUNT - 1) |=> fault_ff)
        else $error("fault not raised on final failed sample");
    a_fault_release: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        sample && !fail |=> !fault_ff ##1 (fault_ff == 1'b0 || $past(sample)))
        else $error("fault not released on recovered fan");
endmodule : fail_filter

/* src/fan_thermal_config_regs.sv */
/*
 register bank of a two-channel temperature monitor and fan controller:
 main configuration, value, offset and limit registers, fan fault path.
 assumes the management bus engine presents byte reads and writes on the
 reg_ port, and the conversion engine gives one-cycle sample pulses.
*/
`timescale 1ns/10ps
`include "fan_params.svh"
module fan_thermal_config_regs #(
    parameter int FAIL_COUNT = `FAN_FAIL_COUNT
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] tach_count_in,
    input wire logic [7:0] analog_count_in,
    input wire logic speed_sample,
    input wire logic [7:0] local_temp_in,
    input wire logic [7:0] remote_temp_in,
    input wire logic [2:0] remote_frac_in,
    input wire logic temp_sample,
    input wire logic pwm_raw,
    input wire logic fault_status_clr,
    output fan_types_pkg::reg_byte_t reg_rdata_ff,
    output logic rd_valid_ff,
    output logic monitor_en_ff,
    output logic speed_sense_select_ff,
    output logic control_select_ff,
    output fan_types_pkg::src_field_t fan_source_ff,
    output logic sw_duty_mode_ff,
    output logic sw_rpm_mode_ff,
    output logic pwm_out_ff,
    output logic int_n_ff,
    output logic fan_fault_status_ff,
    output logic fan_fault_pin_o_ff,
    output logic fan_fault_pin_oe_n_ff
);
    fan_types_pkg::reg_byte_t cfg_ff;
    fan_types_pkg::reg_byte_t fan_speed_ff;
    fan_types_pkg::reg_byte_t fan_limit_ff;
    fan_types_pkg::reg_byte_t local_temp_ff;
    fan_types_pkg::reg_byte_t remote_temp_ff;
    logic [`FRAC_BITS-1:0] remote_frac_ff;
    fan_types_pkg::reg_byte_t local_rdata_ff;
    logic local_hit_ff;
    logic rd_pend_ff;
    fan_types_pkg::reg_byte_t mem_rdata;
    logic filter_fault;

    // address decode
    wire hit_cfg = reg_addr == `ADDR_MAIN_CFG;
    wire hit_frac = reg_addr == `ADDR_REMOTE_FRAC;
    wire hit_speed = reg_addr == `ADDR_FAN_SPEED;
    wire hit_ltemp = reg_addr == `ADDR_LOCAL_TEMP;
    wire hit_rtemp = reg_addr == `ADDR_REMOTE_TEMP;
    wire hit_limit = reg_addr == `ADDR_FAN_LIMIT;
    wire [2:0] mem_idx =
        (reg_addr == `ADDR_LOCAL_CORR) ? 3'h0 :
        (reg_addr == `ADDR_REMOTE_CORR) ? 3'h1 :
        (reg_addr == `ADDR_LOCAL_UPPER) ? 3'h2 :
        (reg_addr == `ADDR_LOCAL_LOWER) ? 3'h3 :
        (reg_addr == `ADDR_LOCAL_CRIT) ? 3'h4 :
        (reg_addr == `ADDR_REMOTE_UPPER) ? 3'h5 :
        (reg_addr == `ADDR_REMOTE_LOWER) ? 3'h6 : 3'h7;
    wire hit_mem = (reg_addr == `ADDR_LOCAL_CORR) ||
                   (reg_addr == `ADDR_REMOTE_CORR) ||
                   (reg_addr == `ADDR_LOCAL_UPPER) ||
                   (reg_addr == `ADDR_LOCAL_LOWER) ||
                   (reg_addr == `ADDR_LOCAL_CRIT) ||
                   (reg_addr == `ADDR_REMOTE_UPPER) ||
                   (reg_addr == `ADDR_REMOTE_LOWER) ||
                   (reg_addr == `ADDR_REMOTE_CRIT);

    // measurements only land while monitoring runs
    wire monitor = cfg_ff[`CFG_MONITOR];
    wire temp_take = temp_sample && monitor;
    wire speed_take = speed_sample && monitor;
    wire [7:0] speed_sel = cfg_ff[`CFG_SPEED_SEL] ? analog_count_in
                                                  : tach_count_in;
    // strictly above the limit, so a limit of ffh never trips
    wire speed_fail = speed_sel > fan_limit_ff;
    wire [1:0] src = cfg_ff[`CFG_SRC_HI:`CFG_SRC_LO];

    // local read selection; unmapped addresses read zero
    wire [7:0] local_rdata =
        hit_cfg ? cfg_ff :
        hit_frac ? {5'h00, remote_frac_ff} :
        hit_speed ? fan_speed_ff :
        hit_ltemp ? local_temp_ff :
        hit_rtemp ? remote_temp_ff :
        hit_limit ? fan_limit_ff : `BYTE_ZERO;

    limit_mem #(
        .WIDTH(8),
        .DEPTH(`LIMIT_DEPTH),
        .AW(3),
        .INIT(`LIMIT_RESETS)
    ) u_limits (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_en(reg_wr && hit_mem),
        .wr_idx(mem_idx),
        .wr_data(reg_wdata),
        .rd_en(reg_rd && hit_mem),
        .rd_idx(mem_idx),
        .rd_data_ff(mem_rdata)
    );

    fail_filter #(
        .FAIL_COUNT(FAIL_COUNT)
    ) u_filter (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sample(speed_take),
        .fail(speed_fail),
        .fault_ff(filter_fault)
    );

    // configuration and fan limit, writable by the host
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_ff <= `CFG_RESET;
            fan_limit_ff <= `FAN_LIMIT_RESET;
        end else if (reg_wr) begin
            if (hit_cfg) cfg_ff <= reg_wdata;
            if (hit_limit) fan_limit_ff <= reg_wdata;
        end
    end

    // value registers: host writes only reach the speed count
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fan_speed_ff <= `BYTE_ZERO;
            local_temp_ff <= `BYTE_ZERO;
            remote_temp_ff <= `BYTE_ZERO;
            remote_frac_ff <= '0;
        end else begin
            if (speed_take) fan_speed_ff <= speed_sel;
            else if (reg_wr && hit_speed) fan_speed_ff <= reg_wdata;
            if (temp_take) begin
                local_temp_ff <= local_temp_in;
                remote_temp_ff <= remote_temp_in;
                remote_frac_ff <= remote_frac_in;
            end
        end
    end

    // read pipeline: capture, then merge with the memory answer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_pend_ff <= 1'b0;
            local_hit_ff <= 1'b0;
            local_rdata_ff <= `BYTE_ZERO;
            rd_valid_ff <= 1'b0;
            reg_rdata_ff <= `BYTE_ZERO;
        end else begin
            rd_pend_ff <= reg_rd;
            if (reg_rd) begin
                local_hit_ff <= !hit_mem;
                local_rdata_ff <= local_rdata;
            end
            rd_valid_ff <= rd_pend_ff;
            if (rd_pend_ff) begin
                reg_rdata_ff <= local_hit_ff ? local_rdata_ff : mem_rdata;
            end
        end
    end

    // fault status: a new failure beats a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fan_fault_status_ff <= 1'b0;
        end else if (speed_take && speed_fail) begin
            fan_fault_status_ff <= 1'b1;
        end else if (fault_status_clr) begin
            fan_fault_status_ff <= 1'b0;
        end
    end

    // registered control outputs seen by the fan engine
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            monitor_en_ff <= 1'b0;
            speed_sense_select_ff <= 1'b0;
            control_select_ff <= 1'b1;
            fan_source_ff <= `SRC_REMOTE;
            sw_duty_mode_ff <= 1'b0;
            sw_rpm_mode_ff <= 1'b0;
            pwm_out_ff <= 1'b1;
            int_n_ff <= 1'b1;
        end else begin
            monitor_en_ff <= monitor;
            speed_sense_select_ff <= cfg_ff[`CFG_SPEED_SEL];
            control_select_ff <= cfg_ff[`CFG_CTRL_SEL];
            fan_source_ff <= src;
            sw_duty_mode_ff <= !cfg_ff[`CFG_CTRL_SEL] &&
                               src == `SRC_REMOTE;
            sw_rpm_mode_ff <= !cfg_ff[`CFG_CTRL_SEL] &&
                              src == `SRC_FASTEST;
            pwm_out_ff <= cfg_ff[`CFG_INVERT] ? pwm_raw : !pwm_raw;
            int_n_ff <= !(cfg_ff[`CFG_INT_EN] &&
                          fan_fault_status_ff);
        end
    end

    // open-drain fan-failure pin: only ever pulls low
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fan_fault_pin_o_ff <= 1'b0;
            fan_fault_pin_oe_n_ff <= 1'b1;
        end else begin
            fan_fault_pin_o_ff <= 1'b0;
            fan_fault_pin_oe_n_ff <= !(cfg_ff[`CFG_FAULT_EN] &&
                                       filter_fault);
        end
    end

    // checks beside the logic; one clock, all quiet while in reset
    a_ro_write_kept: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_wr && hit_ltemp && !temp_take |=> $stable(local_temp_ff))
        else $error("read-only temperature changed by a host write");
    a_monitor_gate: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !cfg_ff[`CFG_MONITOR] |=> $stable(remote_temp_ff))
        else $error("temperature updated with monitoring off");
    a_speed_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !cfg_ff[`CFG_MONITOR] && !(reg_wr && hit_speed)
        |=> $stable(fan_speed_ff))
        else $error("speed count updated with monitoring off");
    a_int_gated: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !cfg_ff[`CFG_INT_EN] |=> int_n_ff)
        else $error("interrupt asserted while disabled");
    a_int_fires: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        cfg_ff[`CFG_INT_EN] && fan_fault_status_ff |=> !int_n_ff)
        else $error("enabled interrupt not asserted on fan fault");
    a_pwm_polarity: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        pwm_raw && !cfg_ff[`CFG_INVERT] |=> !pwm_out_ff)
        else $error("full drive not low at default polarity");
    a_speed_source: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        speed_take && cfg_ff[`CFG_SPEED_SEL]
        |=> fan_speed_ff == $past(analog_count_in))
        else $error("analog speed count not taken");
    a_fault_pin_off: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !cfg_ff[`CFG_FAULT_EN] |=> fan_fault_pin_oe_n_ff)
        else $error("fan-failure pin driven while disabled");
    a_fault_pin_on: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        cfg_ff[`CFG_FAULT_EN] && filter_fault |=> !fan_fault_pin_oe_n_ff)
        else $error("fan-failure pin not driven on filtered fault");
    a_auto_mode: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        cfg_ff[`CFG_CTRL_SEL]
        |=> control_select_ff && !sw_duty_mode_ff && !sw_rpm_mode_ff)
        else $error("software mode shown under automatic control");
    a_sw_duty: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !cfg_ff[`CFG_CTRL_SEL] && src == `SRC_REMOTE
        |=> sw_duty_mode_ff && !sw_rpm_mode_ff)
        else $error("software duty mode not selected");
    a_sw_modes: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !cfg_ff[`CFG_CTRL_SEL] && src == `SRC_FASTEST
        |=> sw_rpm_mode_ff && !sw_duty_mode_ff)
        else $error("software speed mode not selected");
    a_stall_flag: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        speed_take && !cfg_ff[`CFG_SPEED_SEL] && tach_count_in > fan_limit_ff
        |=> fan_fault_status_ff)
        else $error("tach count over limit not flagged");
    a_fault_status: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        speed_take && speed_fail |=> fan_fault_status_ff [*1]
        ##1 int_n_ff == !$past(cfg_ff[`CFG_INT_EN]))
        else $error("fault status or interrupt missed");
    a_remote_msb: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        temp_take |=> remote_temp_ff == $past(remote_temp_in) &&
        remote_frac_ff == $past(remote_frac_in))
        else $error("remote reading not captured");
    a_cfg_reset: assert property (
        @(posedge clk_sys)
        $rose(rst_n) |-> cfg_ff == `CFG_RESET &&
        fan_limit_ff == `FAN_LIMIT_RESET)
        else $error("configuration or fan limit wrong after reset");
    a_read_latency: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_rd && hit_cfg ##1 !reg_wr |=> rd_valid_ff &&
        reg_rdata_ff == $past(cfg_ff, 2))
        else $error("configuration read answer wrong");
endmodule : fan_thermal_config_regs

/* bench/mgmt_host_model.sv */
/*
 byte-side model of the management bus host: single byte reads and
 writes; assumes one-cycle strobes and a registered read answer
*/
`timescale 1ns/10ps
module mgmt_host_model (
    input wire logic clk_sys,
    input wire logic rd_valid_ff,
    input wire fan_types_pkg::reg_byte_t reg_rdata_ff,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    // bus idle from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // data flipped after the strobe so a stale byte never looks right
    task write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : write_byte

    // bounded wait for the answer pulse, sampled off the edge
    task read_byte(input logic [7:0] a, output logic [7:0] d,
                   output logic ok);
        int n;
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        n = 0;
        ok = 1'b0;
        while (n < 6 && !ok) begin
            @(negedge clk_sys);
            ok = (rd_valid_ff === 1'b1);
            n++;
        end
        d = reg_rdata_ff;
    endtask : read_byte
endmodule : mgmt_host_model

/* bench/fan_thermal_config_regs_tb.sv */
/*
 self-checking bench of the fan and thermal register bank; assumes the
 host model drives the register port and this bench the sample inputs
*/
`timescale 1ns/10ps
`include "fan_params.svh"
module fan_thermal_config_regs_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, tach_count_in, local_temp_in;
    logic [7:0] remote_temp_in, analog_count_in;
    logic reg_wr, reg_rd, speed_sample, temp_sample, fault_status_clr;
    logic [2:0] remote_frac_in;
    logic pwm_raw;
    fan_types_pkg::reg_byte_t reg_rdata_ff;
    fan_types_pkg::src_field_t fan_source_ff;
    logic rd_valid_ff, monitor_en_ff, speed_sense_select_ff;
    logic control_select_ff, sw_duty_mode_ff, sw_rpm_mode_ff, pwm_out_ff;
    logic int_n_ff, fan_fault_status_ff, fan_fault_pin_oe_n_ff;
    logic fan_fault_pin_o_ff;
    int err_count = 0;
    int compares = 0;

    always #10 clk_sys = ~clk_sys;

    mgmt_host_model host (.clk_sys(clk_sys), .rd_valid_ff(rd_valid_ff),
        .reg_rdata_ff(reg_rdata_ff), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

    fan_thermal_config_regs uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .tach_count_in(tach_count_in),
        .analog_count_in(analog_count_in), .speed_sample(speed_sample),
        .local_temp_in(local_temp_in), .remote_temp_in(remote_temp_in),
        .remote_frac_in(remote_frac_in), .temp_sample(temp_sample),
        .pwm_raw(pwm_raw), .fault_status_clr(fault_status_clr),
        .reg_rdata_ff(reg_rdata_ff), .rd_valid_ff(rd_valid_ff),
        .monitor_en_ff(monitor_en_ff),
        .speed_sense_select_ff(speed_sense_select_ff),
        .control_select_ff(control_select_ff),
        .fan_source_ff(fan_source_ff), .sw_duty_mode_ff(sw_duty_mode_ff),
        .sw_rpm_mode_ff(sw_rpm_mode_ff), .pwm_out_ff(pwm_out_ff),
        .int_n_ff(int_n_ff), .fan_fault_status_ff(fan_fault_status_ff),
        .fan_fault_pin_o_ff(fan_fault_pin_o_ff),
        .fan_fault_pin_oe_n_ff(fan_fault_pin_oe_n_ff));

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // read one byte and compare; a missing answer pulse counts too
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.read_byte(a, d, ok);
        chk("rd_valid", 8'h01, {7'h0, ok});
        chk($sformatf("reg %h", a), exp, d);
    endtask : rd_chk

    // one-cycle pulse, then two edges so status and pins settle
    task pulse(input int k);
        @(posedge clk_sys);
        if (k == 0) speed_sample <= 1'b1;
        else if (k == 1) temp_sample <= 1'b1;
        else fault_status_clr <= 1'b1;
        @(posedge clk_sys);
        speed_sample <= 1'b0;
        temp_sample <= 1'b0;
        fault_status_clr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : pulse

    task test_reset;
        rd_chk(`ADDR_MAIN_CFG, 8'h90);
        rd_chk(`ADDR_FAN_LIMIT, 8'hff);
        rd_chk(`ADDR_LOCAL_UPPER, 8'h3c);
        rd_chk(`ADDR_LOCAL_LOWER, 8'h00);
        rd_chk(`ADDR_LOCAL_CRIT, 8'h46);
        rd_chk(`ADDR_REMOTE_UPPER, 8'h50);
        rd_chk(`ADDR_REMOTE_LOWER, 8'h00);
        rd_chk(`ADDR_REMOTE_CRIT, 8'h64);
        chk("pwm_out", 8'h00, {7'h0, pwm_out_ff});
        chk("oe_n", 8'h01, {7'h0, fan_fault_pin_oe_n_ff});
        $display("test reset done");
    endtask : test_reset

    // all fields but the interrupt and fault enables set both ways; source 3 in both modes, 0 and 1 in software mode only
    task test_cfg;
        logic [7:0] v [4];
        logic [7:0] c;
        v = '{8'h00, 8'h6d, 8'he4, 8'h20};
        foreach (v[i]) begin
            c = v[i];
            host.write_byte(`ADDR_MAIN_CFG, c);
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            chk("monitor", {7'h0, c[0]}, {7'h0, monitor_en_ff});
            chk("sense", {7'h0, c[2]}, {7'h0, speed_sense_select_ff});
            chk("pwm_out", {7'h0, c[3]}, {7'h0, pwm_out_ff});
            chk("src", {6'h0, c[6:5]}, {6'h0, fan_source_ff});
            chk("ctl", {7'h0, c[7]}, {7'h0, control_select_ff});
            chk("duty", {7'h0, !c[7] && c[6:5] == 2'h0},
                {7'h0, sw_duty_mode_ff});
            chk("rpm", {7'h0, !c[7] && c[6:5] == 2'h3},
                {7'h0, sw_rpm_mode_ff});
            rd_chk(`ADDR_MAIN_CFG, c);
            // drive off must give the opposite pin level
            @(posedge clk_sys);
            pwm_raw <= 1'b0;
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            chk("pwm_off", {7'h0, !c[3]}, {7'h0, pwm_out_ff});
            @(posedge clk_sys);
            pwm_raw <= 1'b1;
        end
        $display("test cfg done");
    endtask : test_cfg

    task test_temps;
        host.write_byte(`ADDR_MAIN_CFG, 8'h00);
        pulse(1);
        rd_chk(`ADDR_LOCAL_TEMP, 8'h00);
        host.write_byte(`ADDR_MAIN_CFG, 8'h01);
        pulse(1);
        rd_chk(`ADDR_LOCAL_TEMP, 8'h33);
        rd_chk(`ADDR_REMOTE_TEMP, 8'h5a);
        rd_chk(`ADDR_REMOTE_FRAC, 8'h05);
        host.write_byte(`ADDR_LOCAL_TEMP, 8'hee);
        host.write_byte(`ADDR_REMOTE_FRAC, 8'hee);
        rd_chk(`ADDR_LOCAL_TEMP, 8'h33);
        rd_chk(`ADDR_REMOTE_FRAC, 8'h05);
        host.write_byte(`ADDR_FAN_SPEED, 8'h42);
        rd_chk(`ADDR_FAN_SPEED, 8'h42);
        rd_chk(8'h30, 8'h00);
        $display("test temps done");
    endtask : test_temps

    // limits first, then enables; count one above limit fails
    task test_fault;
        host.write_byte(`ADDR_LOCAL_CORR, 8'h07);
        host.write_byte(`ADDR_REMOTE_CRIT, 8'h5f);
        rd_chk(`ADDR_LOCAL_CORR, 8'h07);
        rd_chk(`ADDR_REMOTE_CRIT, 8'h5f);
        host.write_byte(`ADDR_FAN_LIMIT, 8'h80);
        host.write_byte(`ADDR_MAIN_CFG, 8'h13);
        tach_count_in <= 8'h81;
        for (int i = 1; i <= 5; i++) begin
            pulse(0);
            chk("status", 8'h01, {7'h0, fan_fault_status_ff});
            chk("int_n", 8'h00, {7'h0, int_n_ff});
            chk("oe_n", {7'h0, i < 5}, {7'h0, fan_fault_pin_oe_n_ff});
            chk("pin_o", 8'h00, {7'h0, fan_fault_pin_o_ff});
            pulse(2);
            chk("clr", 8'h00, {7'h0, fan_fault_status_ff});
        end
        rd_chk(`ADDR_FAN_SPEED, 8'h81);
        @(posedge clk_sys);
        tach_count_in <= 8'h80;
        pulse(0);
        chk("status", 8'h00, {7'h0, fan_fault_status_ff});
        chk("oe_n", 8'h01, {7'h0, fan_fault_pin_oe_n_ff});
        // analog sensing with interrupts off: tach passes, analog fails
        host.write_byte(`ADDR_MAIN_CFG, 8'h15);
        analog_count_in <= 8'h91;
        pulse(0);
        chk("status", 8'h01, {7'h0, fan_fault_status_ff});
        chk("int_n", 8'h01, {7'h0, int_n_ff});
        rd_chk(`ADDR_FAN_SPEED, 8'h91);
        $display("test fault done");
    endtask : test_fault

    task print_verdict;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        print_verdict;
    end

    initial begin
        tach_count_in = 8'h00;
        analog_count_in = 8'h00;
        local_temp_in = 8'h33;
        remote_temp_in = 8'h5a;
        remote_frac_in = 3'h5;
        speed_sample = 1'b0;
        temp_sample = 1'b0;
        fault_status_clr = 1'b0;
        pwm_raw = 1'b1;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        test_reset;
        test_cfg;
        test_temps;
        test_fault;
        print_verdict;
    end
endmodule : fan_thermal_config_regs_tb
